// *** rtl/sce_pkg.sv ***
package sce_pkg;
  // ---------------------------------------------------------------------------
  // Bus and command encodings
  // ---------------------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR   = 7'h76;
  localparam logic [7:0] CMD_RESET     = 8'h1E;
  localparam logic [7:0] CMD_RESULT    = 8'h00;
  localparam logic [7:0] CMD_MEM_BASE  = 8'hA0;
  localparam logic [7:0] CMD_MEM_LAST  = 8'hAC;
  localparam logic [7:0] CMD_PRES_BASE = 8'h40;
  localparam logic [7:0] CMD_TEMP_BASE = 8'h50;
  localparam logic [2:0] RATIO_MAX     = 3'h4;
  localparam int         RATIO_LSB     = 1;
  localparam int         RATIO_MSB     = 3;
  localparam int         MEM_WORDS     = 7;
  localparam int         PTYPE_LSB     = 5;
  localparam int         PTYPE_MSB     = 11;
  localparam int         CRC_LSB       = 12;
  // Arbitrary neutral product-type code
  localparam logic [6:0] PTYPE_CODE    = 7'h2A;
  // Arbitrary neutral CRC nibble
  localparam logic [3:0] CRC_CODE      = 4'h5;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int CONV_US_256  = 600;
  localparam int CONV_CYC_256 = CONV_US_256 * CLK_MHZ;
  localparam int SCL_HALF     = 320;
  localparam int RESULT_BITS  = 24;
  localparam int WORD_BITS    = 16;
  // ---------------------------------------------------------------------------
  // Controller register map, Wishbone byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int CMD_RD  = 8;
  localparam int CMD_RLEN = 9;
  localparam int CMD_REC = 10;
endpackage : sce_pkg

// *** rtl/sce_if.sv ***
`timescale 1ns/1ps
interface sce_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  wire  sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface : sce_if

// *** rtl/sce_device.sv ***
`timescale 1ns/1ps
// Functional notes
// - Answer only at target address 0x76
// - Commands are single bytes
// - Five command groups, reset and result codes
// - Conversion codes carry ratio in bits 3:1
// - Memory read selects word from bits 3:1
// - Result read 24 bits, memory 16
// - Reset reloads calibration memory, recovers state
// - Controller clears stuck bus, then resets
// - Seven 16-bit calibration words
// - Memory read: command write, then read
// - Stale or missing result reads zero
// - Read during conversion gives zero, corrupts
// - Controller never overlaps conversions
// - Busy until done, then hold result
// - 24 bits MSB first, ack per byte
// - Word 0 config and CRC, 1-6 coefficients
// - Word 0 bits 11:5 product code
// - 4-bit CRC in top of word 0
// - Controller waits maximum conversion time; the test reads the result mid-conversion instead
module sce_device (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  sce_if.dev               bus,
  input  wire logic [23:0] sample_i,
  output logic             busy_o,
  output logic             corrupt_o
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------------------
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_d_ff;
  logic       sda_d_ff;
  always_ff @(posedge clk_i) begin
    scl_sync_ff <= {scl_sync_ff[0], bus.scl};
    sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    scl_d_ff    <= scl_sync_ff[1];
    sda_d_ff    <= sda_sync_ff[1];
  end
  wire scl_s  = scl_sync_ff[1];
  wire sda_s  = sda_sync_ff[1];
  wire scl_rise = scl_s && !scl_d_ff;
  wire scl_fall = !scl_s && scl_d_ff;
  wire start_c  = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  wire stop_c   = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // ---------------------------------------------------------------------------
  // Calibration memory
  // ---------------------------------------------------------------------------
  localparam int MEM_WORDS_L = sce_pkg::MEM_WORDS;
  logic [15:0] mem_ff [MEM_WORDS_L];
  logic [15:0] word0;
  always_comb begin
    word0 = 16'h0000;
    word0[15:sce_pkg::CRC_LSB] = sce_pkg::CRC_CODE;
    word0[sce_pkg::PTYPE_MSB:sce_pkg::PTYPE_LSB] = sce_pkg::PTYPE_CODE;
  end

  // ---------------------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK} sce_st_t;
  sce_st_t     st_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  sh_ff;
  logic [23:0] tx_ff;
  logic [1:0]  rd_bytes_ff;
  logic        rd_mode_ff;
  logic        mem_sel_ff;
  logic [2:0]  mem_addr_ff;
  logic        sda_o_ff;
  logic        sda_oe_ff;
  logic        cmd_stb_ff;
  logic [7:0]  cmd_ff;
  logic        rd_start_ff;
  logic [23:0] result_ff;
  logic        result_ok_ff;
  logic [31:0] conv_cnt_ff;
  logic        busy_ff;
  logic        corrupt_ff;
  logic [23:0] result_out;
  assign result_out = (result_ok_ff && !busy_ff) ? result_ff : 24'h0000_00;

  always_ff @(posedge clk_i) begin
    cmd_stb_ff  <= 1'b0;
    rd_start_ff <= 1'b0;
    if (rst_i || stop_c) begin
      st_ff     <= S_IDLE;
      sda_oe_ff <= 1'b0;
      sda_o_ff  <= 1'b1;
    end else if (start_c) begin
      st_ff     <= S_ADDR;
      bit_ff    <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        S_IDLE: ;
        S_ADDR, S_WR: if (scl_rise) begin
          sh_ff  <= {sh_ff[6:0], sda_s};
          bit_ff <= bit_ff + 4'h1;
        end else if (scl_fall && bit_ff == 4'h8) begin
          if (st_ff == S_WR || sh_ff[7:1] == sce_pkg::TARGET_ADDR) begin
            sda_oe_ff <= 1'b1;
            sda_o_ff  <= 1'b0;
            st_ff     <= (st_ff == S_ADDR) ? S_ADDR_ACK : S_WR_ACK;
            if (st_ff == S_WR) begin
              cmd_ff     <= sh_ff;
              cmd_stb_ff <= 1'b1;
            end else begin
              rd_mode_ff <= sh_ff[0];
              if (sh_ff[0]) rd_start_ff <= 1'b1;
            end
          end else begin
            st_ff <= S_IDLE;
          end
        end
        S_ADDR_ACK, S_WR_ACK: if (scl_fall) begin
          bit_ff <= 4'h0;
          if (st_ff == S_ADDR_ACK && rd_mode_ff) begin
            sda_oe_ff <= 1'b1;
            sda_o_ff  <= tx_ff[23];
            st_ff     <= S_RD;
          end else begin
            sda_oe_ff <= 1'b0;
            st_ff     <= S_WR;
          end
        end
        S_RD: if (scl_fall) begin
          if (bit_ff == 4'h7) begin
            sda_oe_ff <= 1'b0;
            st_ff     <= S_RD_ACK;
          end else begin
            sda_o_ff <= tx_ff[22];
          end
          tx_ff  <= {tx_ff[22:0], 1'b0};
          bit_ff <= bit_ff + 4'h1;
        end
        // Ack seen: next byte's MSB goes out after the fall, as after the address
        S_RD_ACK: if (scl_rise) begin
          if (sda_s) st_ff <= S_IDLE;
          else st_ff <= S_ADDR_ACK;
        end
      endcase
    end
    if (rd_start_ff) begin
      tx_ff <= mem_sel_ff ? {mem_ff[mem_addr_ff], 8'h00}
                          : result_out;
    end
  end

  // Read-ack handling: controller drives ack while the clock is low, device samples it on the rise, resumes after the fall
  // ---------------------------------------------------------------------------
  // Command decode and conversion
  // ---------------------------------------------------------------------------
  wire [2:0] ratio    = cmd_ff[sce_pkg::RATIO_MSB:sce_pkg::RATIO_LSB];
  wire       ratio_ok = ratio <= sce_pkg::RATIO_MAX && !cmd_ff[0];
  wire       is_conv  = ratio_ok && ({cmd_ff[7:4], 4'h0} == sce_pkg::CMD_PRES_BASE ||
                                     {cmd_ff[7:4], 4'h0} == sce_pkg::CMD_TEMP_BASE);
  wire       is_mem   = cmd_ff >= sce_pkg::CMD_MEM_BASE && cmd_ff <= sce_pkg::CMD_MEM_LAST &&
                        !cmd_ff[0] && ratio < 3'(sce_pkg::MEM_WORDS);

  always_ff @(posedge clk_i) begin
    if (rst_i || (cmd_stb_ff && cmd_ff == sce_pkg::CMD_RESET)) begin
      busy_ff      <= 1'b0;
      result_ok_ff <= 1'b0;
      corrupt_ff   <= 1'b0;
      conv_cnt_ff  <= 32'h0000_0000;
      mem_sel_ff   <= 1'b0;
      mem_addr_ff  <= 3'h0;
      mem_ff[0]    <= word0;
      for (int i = 1; i < MEM_WORDS_L; i++) mem_ff[i] <= 16'(i * 16'h1111);
    end else begin
      if (cmd_stb_ff) begin
        if (is_conv && !busy_ff) begin
          busy_ff     <= 1'b1;
          corrupt_ff  <= 1'b0;
          conv_cnt_ff <= 32'(sce_pkg::CONV_CYC_256) << ratio;
        end else if (is_mem) begin
          mem_sel_ff  <= 1'b1;
          mem_addr_ff <= ratio;
        end else if (cmd_ff == sce_pkg::CMD_RESULT) begin
          mem_sel_ff <= 1'b0;
        end
      end
      if (rd_start_ff && !mem_sel_ff) begin
        result_ok_ff <= 1'b0;
        if (busy_ff) corrupt_ff <= 1'b1;
      end
      if (busy_ff) begin
        if (conv_cnt_ff <= 32'h0000_0001) begin
          busy_ff      <= 1'b0;
          result_ok_ff <= 1'b1;
          result_ff    <= (corrupt_ff || (rd_start_ff && !mem_sel_ff)) ? ~sample_i : sample_i;
        end
        conv_cnt_ff <= conv_cnt_ff - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    busy_o    <= rst_i ? 1'b0 : busy_ff;
    corrupt_o <= rst_i ? 1'b0 : corrupt_ff;
  end
  assign bus.sda_dev_o  = sda_o_ff;
  assign bus.sda_dev_oe = sda_oe_ff;
endmodule : sce_device

// *** rtl/sce_host.sv ***
`timescale 1ns/1ps
module sce_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  sce_if.host              bus,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  // ---------------------------------------------------------------------------
  // Bus registers
  // ---------------------------------------------------------------------------
  logic [7:0]  cmd_ff;
  logic        rd_ff;
  logic        rlen_ff;
  logic        rec_ff;
  logic        nack_ff;
  logic [23:0] data_ff;
  logic        go_ff;
  typedef enum logic [2:0] {H_IDLE, H_REC, H_START, H_BYTE, H_ACK, H_STOP} sce_hst_t;
  sce_hst_t    st_ff;
  wire busy = st_ff != H_IDLE;

  always_ff @(posedge clk_i) begin
    go_ff <= 1'b0;
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cmd_ff   <= 8'h00;
      rd_ff    <= 1'b0;
      rlen_ff  <= 1'b0;
      rec_ff   <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h0000_0000;
        if (wb_we_i && wb_adr_i == sce_pkg::REG_CMD && wb_sel_i[0] && !busy) begin
          cmd_ff <= wb_dat_i[7:0];
          if (wb_sel_i[1]) begin
            rd_ff   <= wb_dat_i[sce_pkg::CMD_RD];
            rlen_ff <= wb_dat_i[sce_pkg::CMD_RLEN];
            rec_ff  <= wb_dat_i[sce_pkg::CMD_REC];
          end
          go_ff <= 1'b1;
        end
        if (!wb_we_i) begin
          unique case (wb_adr_i)
            sce_pkg::REG_STATUS: wb_dat_o <= {30'h0, nack_ff, busy};
            sce_pkg::REG_DATA:   wb_dat_o <= {8'h00, data_ff};
            default:             wb_dat_o <= {24'h0, cmd_ff};
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------------------
  logic [1:0]  sda_sync_ff;
  logic [9:0]  div_ff;
  logic        ph_ff;
  logic [3:0]  bit_ff;
  logic [4:0]  rec_cnt_ff;
  logic [1:0]  byte_ff;
  logic        addr_ph_ff;
  logic [7:0]  sh_ff;
  logic        scl_ff;
  logic        sda_ff;
  // Two ticks per clock half period (one during recovery), four per bit
  wire tick = div_ff == 10'(sce_pkg::SCL_HALF / 2 - 1);
  wire [1:0] last_byte = rd_ff ? (rlen_ff ? 2'h2 : 2'h1) : 2'h0;

  always_ff @(posedge clk_i) begin
    sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    if (rst_i) begin
      st_ff <= H_IDLE;
      div_ff <= 10'h000;
      ph_ff <= 1'b0;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      nack_ff <= 1'b0;
      data_ff <= 24'h0000_00;
    end else if (go_ff) begin
      st_ff <= rec_ff ? H_REC : H_START;
      rec_cnt_ff <= 5'h12;
      div_ff <= 10'h000;
      ph_ff <= 1'b0;
      nack_ff <= 1'b0;
      if (rd_ff) data_ff <= 24'h0000_00;
    end else if (busy) begin
      div_ff <= tick ? 10'h000 : div_ff + 10'h001;
      if (tick) begin
        ph_ff <= !ph_ff;
        unique case (st_ff)
          H_IDLE: ;
          H_REC: begin
            sda_ff <= 1'b1;
            scl_ff <= !scl_ff;
            rec_cnt_ff <= rec_cnt_ff - 5'h01;
            if (rec_cnt_ff == 5'h01) st_ff <= H_START;
          end
          H_START: if (!ph_ff) sda_ff <= 1'b0;
          else begin
            scl_ff <= 1'b0;
            sh_ff <= {sce_pkg::TARGET_ADDR, rd_ff};
            bit_ff <= 4'h0;
            byte_ff <= 2'h0;
            addr_ph_ff <= 1'b1;
            st_ff <= H_BYTE;
          end
          H_BYTE: if (!ph_ff) begin
            sda_ff <= (rd_ff && !addr_ph_ff) ? 1'b1 : sh_ff[7];
          end else if (!scl_ff) scl_ff <= 1'b1;
          else begin
            if (rd_ff && !addr_ph_ff) data_ff <= {data_ff[22:0], sda_sync_ff[1]};
            sh_ff <= {sh_ff[6:0], 1'b0};
            scl_ff <= 1'b0;
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == 4'h7) st_ff <= H_ACK;
          end
          H_ACK: if (!ph_ff) begin
            sda_ff <= !(rd_ff && !addr_ph_ff && byte_ff != last_byte);
          end else if (!scl_ff) begin
            scl_ff <= 1'b1;
            if ((!rd_ff || addr_ph_ff) && sda_sync_ff[1]) nack_ff <= 1'b1;
          end else begin
            scl_ff <= 1'b0;
            bit_ff <= 4'h0;
            if (addr_ph_ff) begin
              addr_ph_ff <= 1'b0;
              sh_ff <= cmd_ff;
              st_ff <= (nack_ff) ? H_STOP : H_BYTE;
            end else if (byte_ff == last_byte || !rd_ff) begin
              st_ff <= H_STOP;
            end else begin
              byte_ff <= byte_ff + 2'h1;
              st_ff <= H_BYTE;
            end
          end
          H_STOP: if (!ph_ff) sda_ff <= 1'b0;
          else if (!scl_ff) scl_ff <= 1'b1;
          else begin
            sda_ff <= 1'b1;
            st_ff <= H_IDLE;
          end
        endcase
      end
    end
  end
  assign bus.scl         = scl_ff;
  assign bus.sda_host_o  = sda_ff;
  assign bus.sda_host_oe = !sda_ff;
endmodule : sce_host

// *** verif/sce_properties.sv ***
`timescale 1ns/1ps
module sce_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  localparam int LOW_MAX = 700;
  logic       scl_ff;
  logic       sda_ff;
  logic       frame_ff;
  logic       first_ff;
  logic       rd_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [1:0] nbytes_ff;
  logic       rise;
  logic       start;
  logic       stop;
  logic       dev_pull;
  logic       host_pull;
  // ---------------------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------------------
  assign rise      = scl && !scl_ff;
  assign start     = scl && scl_ff && sda_ff && !sda;
  assign stop      = scl && scl_ff && !sda_ff && sda;
  assign dev_pull  = sda_dev_oe && !sda_dev_o;
  assign host_pull = sda_host_oe && !sda_host_o;
  always_ff @(posedge clk_i) begin
    scl_ff <= rst_i ? 1'b1 : scl;
    sda_ff <= rst_i ? 1'b1 : sda;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || stop) begin
      frame_ff <= 1'b0;
    end else if (start) begin
      frame_ff <= 1'b1;
    end
  end
  // Recovery clocks outside a frame also count; the next start clears them
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      bit_ff    <= 4'h0;
      first_ff  <= 1'b1;
      nbytes_ff <= 2'h0;
      shift_ff  <= 8'h00;
      rd_ff     <= rst_i ? 1'b0 : rd_ff;
    end else if (rise && bit_ff < 4'h8) begin
      bit_ff   <= bit_ff + 4'h1;
      shift_ff <= {shift_ff[6:0], sda};
    end else if (rise) begin
      bit_ff    <= 4'h0;
      first_ff  <= 1'b0;
      rd_ff     <= first_ff ? shift_ff[0] : rd_ff;
      nbytes_ff <= first_ff ? nbytes_ff : nbytes_ff + 2'h1;
    end
  end
  // ---------------------------------------------------------------------------
  // Wire properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("serial clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("serial clock low phase too short");
  a_scl_low_max: assert property ($fell(scl) |-> ##[1:LOW_MAX] scl)
    else $error("serial clock stuck low");
  a_dev_hold_high: assert property (scl && scl_ff |-> $stable(dev_pull))
    else $error("device changed data while clock high");
  a_dev_idle_quiet: assert property (!frame_ff |-> !dev_pull)
    else $error("device pulled data outside a frame");
  a_addr_ack: assert property (rise && frame_ff && first_ff && bit_ff == 4'h8
    && shift_ff[7:1] == sce_pkg::TARGET_ADDR |-> !sda) else $error("own address not acknowledged");
  a_addr_quiet: assert property (rise && frame_ff && first_ff && bit_ff == 4'h8
    && shift_ff[7:1] != sce_pkg::TARGET_ADDR |-> !dev_pull) else $error("foreign address acknowledged");
  a_rd_ack_free: assert property (rise && frame_ff && rd_ff && !first_ff && bit_ff == 4'h8 |-> !dev_pull)
    else $error("device pulled controller acknowledge slot");
  a_dev_data_quiet: assert property (rise && frame_ff && bit_ff < 4'h8 && (first_ff || !rd_ff) |-> !dev_pull)
    else $error("device pulled data in a written byte");
  // Checked at the fall: the stop's own rise follows the controller pulling data low
  a_host_rd_quiet: assert property (!scl && scl_ff && frame_ff && rd_ff && !first_ff && bit_ff != 4'h0
    |-> !host_pull) else $error("controller pulled data in a read byte");
  a_rd_length: assert property (stop && frame_ff && rd_ff |-> (nbytes_ff == 2'h2 || nbytes_ff == 2'h3))
    else $error("read frame length not two or three bytes");
  c_start: cover property (start);
  c_rd_addr: cover property (rise && first_ff && bit_ff == 4'h8 && shift_ff[0]);
  c_rd_three: cover property (stop && rd_ff && nbytes_ff == 2'h3);
endmodule : sce_properties

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  wb_adr    = 4'h0;
  logic [31:0] wb_wdat   = 32'h0000_0000;
  logic        wb_we     = 1'b0;
  logic [3:0]  wb_sel    = 4'h0;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic [23:0] sample    = 24'h00_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        busy;
  logic        corrupt;
  logic [31:0] rd;
  logic [2:0]  ratio;
  logic        temp;
  int          bad_count = 0;
  int          tests_run = 0;
  int          seed_v;
  sce_if bus_if();
  sce_device sce_device_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .sample_i(sample),
    .busy_o(busy), .corrupt_o(corrupt));
  sce_host sce_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
    .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  sce_properties sce_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_host_o(bus_if.sda_host_o), .sda_host_oe(bus_if.sda_host_oe), .sda_dev_o(bus_if.sda_dev_o),
    .sda_dev_oe(bus_if.sda_dev_oe));
  always #2 clk_i = ~clk_i;
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] conv_byte(input logic t, input logic [2:0] r);
    return (t ? sce_pkg::CMD_TEMP_BASE : sce_pkg::CMD_PRES_BASE) | {4'h0, r, 1'b0};
  endfunction : conv_byte
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic wb_xfer(input logic [3:0] adr, input logic we, input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr  <= adr;
    wb_we   <= we;
    wb_wdat <= wdat;
    wb_sel  <= 4'hF;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    if (n >= 50) begin
      check("wb ack", 32'h0000_0001, 32'h0000_0000);
    end
  endtask : wb_xfer
  // Polls until the serial transfer is over; the wait is bounded
  task automatic run_cmd(input logic [31:0] cmd);
    logic [31:0] st;
    int          n;
    wb_xfer(sce_pkg::REG_CMD, 1'b1, cmd, st);
    n = 0;
    do begin
      wb_xfer(sce_pkg::REG_STATUS, 1'b0, 32'h0000_0000, st);
      n++;
    end while (st[sce_pkg::ST_BUSY] !== 1'b0 && n < 20000);
    check("status busy", 32'h0000_0000, {31'h0, st[sce_pkg::ST_BUSY]});
    check("status nack", 32'h0000_0000, {31'h0, st[sce_pkg::ST_NACK]});
  endtask : run_cmd
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed_v = $urandom(76382);
    repeat (20) @(posedge clk_i);
    rst_i  <= 1'b0;
    sample <= 24'($urandom);
    ratio  = 3'($urandom_range(4, 0));
    temp   = 1'($urandom);
    run_cmd({21'h0_0000, 3'b100, sce_pkg::CMD_RESET});
    check("busy after reset", 32'h0000_0000, {31'h0, busy});
    // Ratio field beyond the top step is not a command
    run_cmd(32'h0000_004A);
    check("busy unknown cmd", 32'h0000_0000, {31'h0, busy});
    run_cmd({24'h00_0000, sce_pkg::CMD_MEM_BASE});
    run_cmd(32'h0000_0100);
    wb_xfer(sce_pkg::REG_DATA, 1'b0, 32'h0000_0000, rd);
    check("word0 crc", {28'h0, sce_pkg::CRC_CODE}, {28'h0, rd[15:12]});
    check("word0 type", {25'h0, sce_pkg::PTYPE_CODE}, {25'h0, rd[11:5]});
    check("idle before conv", 32'h0000_0000, {31'h0, busy});
    run_cmd({24'h00_0000, conv_byte(temp, ratio)});
    check("busy conv", 32'h0000_0001, {31'h0, busy});
    run_cmd({24'h00_0000, sce_pkg::CMD_RESULT});
    run_cmd(32'h0000_0300);
    wb_xfer(sce_pkg::REG_DATA, 1'b0, 32'h0000_0000, rd);
    check("early result", 32'h0000_0000, rd);
    check("corrupt flag", 32'h0000_0001, {31'h0, corrupt});
    check("busy kept", 32'h0000_0001, {31'h0, busy});
    wb_xfer(4'hC, 1'b0, 32'h0000_0000, rd);
    check("unmapped read", {24'h00_0000, sce_pkg::CMD_RESULT}, rd);
    results();
  end
  initial begin
    // Seven frames near the top serial rate take about 108k cycles
    repeat (112000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule : tb_top
